/* File: core/fifo_host_pkg.sv */
// Constants for the controller that drives the 64x9 ripple-through store
package fifo_host_pkg;

  // ==========================================================
  // Word layout and store size
  localparam int WORD_W = 9;
  localparam int STORE_DEPTH = 64;
  localparam int CNT_W = 4;

  // ==========================================================
  // Clock
  localparam int CLK_PERIOD_NS = 40;

  // ==========================================================
  // Pin timing in ns, worst case over supply and temperature
  localparam int CLEAR_LOW_NS = 70;
  localparam int CLEAR_REMOVAL_NS = 80;
  localparam int LOAD_WIDTH_NS = 50;
  localparam int DATA_HOLD_NS = 135;
  localparam int LOAD_TO_READY_NS = 235;
  localparam int UNLOAD_WIDTH_NS = 100;
  localparam int UNLOAD_TO_FLAG_NS = 315;
  localparam int FLAG_TO_WORD_NS = 35;
  localparam int ENABLE_TO_WORD_NS = 175;

  // Least time to whole cycles, rounded up, never below one
  function automatic logic [CNT_W-1:0] cycles_ceil(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction

  function automatic logic [CNT_W-1:0] max_cnt(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  // ==========================================================
  // Cycle counts
  localparam logic [CNT_W-1:0] CLEAR_CYC = cycles_ceil(CLEAR_LOW_NS);
  localparam logic [CNT_W-1:0] RECOVER_CYC =
    max_cnt(cycles_ceil(CLEAR_REMOVAL_NS), cycles_ceil(ENABLE_TO_WORD_NS));
  localparam logic [CNT_W-1:0] LOAD_HIGH_CYC = max_cnt(cycles_ceil(LOAD_WIDTH_NS), cycles_ceil(DATA_HOLD_NS));
  localparam logic [CNT_W-1:0] LOAD_LOW_CYC =
    max_cnt(cycles_ceil(LOAD_WIDTH_NS), cycles_ceil(LOAD_TO_READY_NS) - LOAD_HIGH_CYC);
  localparam logic [CNT_W-1:0] WORD_SETTLE_CYC = cycles_ceil(FLAG_TO_WORD_NS);
  localparam logic [CNT_W-1:0] UNLOAD_HIGH_CYC = cycles_ceil(UNLOAD_WIDTH_NS);
  localparam logic [CNT_W-1:0] UNLOAD_LOW_CYC =
    max_cnt(cycles_ceil(UNLOAD_WIDTH_NS), cycles_ceil(UNLOAD_TO_FLAG_NS) - UNLOAD_HIGH_CYC);

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {INIT_CLEAR, INIT_RECOVER, INIT_RUN} init_state_e;
  typedef enum logic [1:0] {LOAD_IDLE, LOAD_HIGH, LOAD_LOW} load_state_e;
  typedef enum logic [1:0] {UNLOAD_IDLE, UNLOAD_SETTLE, UNLOAD_HIGH, UNLOAD_LOW} unload_state_e;

endpackage

/* File: core/two_entry_buffer.sv */
// Two-entry buffer with valid and full on the write side, valid and ready on the read side
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [fifo_host_pkg::WORD_W-1:0] in_data,
  output logic in_full,
  output logic out_valid,
  output logic [fifo_host_pkg::WORD_W-1:0] out_data,
  input wire logic out_ready
);

  // ==========================================================
  // Slot 0 is the head, slot 1 the tail
  logic v0_q, v0_d, v1_q, v1_d;
  logic [fifo_host_pkg::WORD_W-1:0] d0_q, d0_d, d1_q, d1_d;
  logic push, pop;

  assign push = in_valid && !v1_q;
  assign pop = v0_q && out_ready;
  assign in_full = v1_q;
  assign out_valid = v0_q;
  assign out_data = d0_q;

  always_comb
  begin
    v0_d = v0_q;
    v1_d = v1_q;
    d0_d = d0_q;
    d1_d = d1_q;
    if (pop && push)
    begin
      if (v1_q)
      begin
        d0_d = d1_q;
        d1_d = in_data;
      end
      else
      begin
        d0_d = in_data;
      end
    end
    else if (pop)
    begin
      d0_d = d1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    else if (push)
    begin
      if (!v0_q)
      begin
        d0_d = in_data;
        v0_d = 1'b1;
      end
      else
      begin
        d1_d = in_data;
        v1_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      d0_q <= '0;
      d1_q <= '0;
    end
    else
    begin
      v0_q <= v0_d;
      v1_q <= v1_d;
      d0_q <= d0_d;
      d1_q <= d1_d;
    end
  end

endmodule // two_entry_buffer
`default_nettype wire

/* File: core/fifo_host.sv */
// Controller that loads and unloads the 64x9 ripple-through store over its pins
//
// Summary of operation
// - Pulse master clear low before any load.
// - Load only while input ready is high.
// - Return load strobe low to finish load.
// - Holding load high when full is allowed.
// - Drive unload strobe low before next removal.
// - Never overfill; burst ignores flags. Here each load and unload waits for its flag.
// - Parallel flags combine through one gate.
// - Held strobes need extra composite flag logic.
`timescale 1ns/1ps
`default_nettype none
module fifo_host (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wr_valid,
  input wire logic [fifo_host_pkg::WORD_W-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [fifo_host_pkg::WORD_W-1:0] rd_data,
  input wire logic rd_ready,
  output logic link_ready,
  output logic master_clear_n,
  output logic load_strobe,
  output logic [fifo_host_pkg::WORD_W-1:0] write_word,
  input wire logic input_ready,
  output logic unload_strobe_n,
  output logic output_enable_n,
  input wire logic output_ready_flag,
  input wire logic [fifo_host_pkg::WORD_W-1:0] read_word
);

  // ==========================================================
  // Registered flag inputs
  logic in_rdy_q, out_rdy_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      in_rdy_q <= 1'b0;
      out_rdy_q <= 1'b0;
    end
    else
    begin
      in_rdy_q <= input_ready;
      out_rdy_q <= output_ready_flag;
    end
  end

  // ==========================================================
  // Initial clear sequence
  fifo_host_pkg::init_state_e init_q, init_d;
  logic [fifo_host_pkg::CNT_W-1:0] init_cnt_q, init_cnt_d;
  logic clear_n_q, clear_n_d;
  logic oe_n_q, oe_n_d;
  logic run_q, run_d;

  always_comb
  begin
    init_d = init_q;
    init_cnt_d = init_cnt_q;
    clear_n_d = clear_n_q;
    oe_n_d = oe_n_q;
    run_d = run_q;
    case (init_q)
      fifo_host_pkg::INIT_CLEAR:
      begin
        clear_n_d = 1'b0;
        if (init_cnt_q == fifo_host_pkg::CLEAR_CYC - 4'h1)
        begin
          init_d = fifo_host_pkg::INIT_RECOVER;
          init_cnt_d = '0;
          clear_n_d = 1'b1;
          oe_n_d = 1'b0;
        end
        else
        begin
          init_cnt_d = init_cnt_q + 4'h1;
        end
      end
      fifo_host_pkg::INIT_RECOVER:
      begin
        if (init_cnt_q == fifo_host_pkg::RECOVER_CYC - 4'h1)
        begin
          init_d = fifo_host_pkg::INIT_RUN;
          run_d = 1'b1;
        end
        else
        begin
          init_cnt_d = init_cnt_q + 4'h1;
        end
      end
      default:
      begin
        run_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      init_q <= fifo_host_pkg::INIT_CLEAR;
      init_cnt_q <= '0;
      clear_n_q <= 1'b0;
      oe_n_q <= 1'b1;
      run_q <= 1'b0;
    end
    else
    begin
      init_q <= init_d;
      init_cnt_q <= init_cnt_d;
      clear_n_q <= clear_n_d;
      oe_n_q <= oe_n_d;
      run_q <= run_d;
    end
  end

  // ==========================================================
  // Load sequencer
  fifo_host_pkg::load_state_e load_q, load_d;
  logic [fifo_host_pkg::CNT_W-1:0] load_cnt_q, load_cnt_d;
  logic load_stb_q, load_stb_d;
  logic wr_ready_q, wr_ready_d;
  logic [fifo_host_pkg::WORD_W-1:0] word_q, word_d;

  always_comb
  begin
    load_d = load_q;
    load_cnt_d = load_cnt_q;
    load_stb_d = load_stb_q;
    wr_ready_d = 1'b0;
    word_d = word_q;
    case (load_q)
      fifo_host_pkg::LOAD_IDLE:
      begin
        // Wait for a free input stage; load strobe stays low meanwhile
        if (wr_ready_q && wr_valid)
        begin
          word_d = wr_data;
          load_stb_d = 1'b1;
          load_cnt_d = '0;
          load_d = fifo_host_pkg::LOAD_HIGH;
        end
        else
        begin
          wr_ready_d = run_q && in_rdy_q;
        end
      end
      fifo_host_pkg::LOAD_HIGH:
      begin
        if (load_cnt_q == fifo_host_pkg::LOAD_HIGH_CYC - 4'h1)
        begin
          load_stb_d = 1'b0;
          load_cnt_d = '0;
          load_d = fifo_host_pkg::LOAD_LOW;
        end
        else
        begin
          load_cnt_d = load_cnt_q + 4'h1;
        end
      end
      default:
      begin
        // Let the input ready flag settle before trusting it again
        if (load_cnt_q == fifo_host_pkg::LOAD_LOW_CYC)
        begin
          load_d = fifo_host_pkg::LOAD_IDLE;
        end
        else
        begin
          load_cnt_d = load_cnt_q + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      load_q <= fifo_host_pkg::LOAD_IDLE;
      load_cnt_q <= '0;
      load_stb_q <= 1'b0;
      wr_ready_q <= 1'b0;
      word_q <= '0;
    end
    else
    begin
      load_q <= load_d;
      load_cnt_q <= load_cnt_d;
      load_stb_q <= load_stb_d;
      wr_ready_q <= wr_ready_d;
      word_q <= word_d;
    end
  end

  // ==========================================================
  // Unload sequencer
  fifo_host_pkg::unload_state_e unload_q, unload_d;
  logic [fifo_host_pkg::CNT_W-1:0] unload_cnt_q, unload_cnt_d;
  logic unload_n_q, unload_n_d;
  logic push;
  logic buf_full;

  always_comb
  begin
    unload_d = unload_q;
    unload_cnt_d = unload_cnt_q;
    unload_n_d = unload_n_q;
    push = 1'b0;
    case (unload_q)
      fifo_host_pkg::UNLOAD_IDLE:
      begin
        if (run_q && out_rdy_q && !buf_full)
        begin
          unload_cnt_d = '0;
          unload_d = fifo_host_pkg::UNLOAD_SETTLE;
        end
      end
      fifo_host_pkg::UNLOAD_SETTLE:
      begin
        if (unload_cnt_q == fifo_host_pkg::WORD_SETTLE_CYC - 4'h1)
        begin
          push = 1'b1;
          unload_n_d = 1'b1;
          unload_cnt_d = '0;
          unload_d = fifo_host_pkg::UNLOAD_HIGH;
        end
        else
        begin
          unload_cnt_d = unload_cnt_q + 4'h1;
        end
      end
      fifo_host_pkg::UNLOAD_HIGH:
      begin
        if (unload_cnt_q == fifo_host_pkg::UNLOAD_HIGH_CYC - 4'h1)
        begin
          unload_n_d = 1'b0;
          unload_cnt_d = '0;
          unload_d = fifo_host_pkg::UNLOAD_LOW;
        end
        else
        begin
          unload_cnt_d = unload_cnt_q + 4'h1;
        end
      end
      default:
      begin
        // Output ready is stale until the refill has had time to show
        if (unload_cnt_q == fifo_host_pkg::UNLOAD_LOW_CYC - 4'h1)
        begin
          unload_d = fifo_host_pkg::UNLOAD_IDLE;
        end
        else
        begin
          unload_cnt_d = unload_cnt_q + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      unload_q <= fifo_host_pkg::UNLOAD_IDLE;
      unload_cnt_q <= '0;
      unload_n_q <= 1'b0;
    end
    else
    begin
      unload_q <= unload_d;
      unload_cnt_q <= unload_cnt_d;
      unload_n_q <= unload_n_d;
    end
  end

  // ==========================================================
  // Read-side buffer
  two_entry_buffer u_buffer (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(push),
    .in_data(read_word),
    .in_full(buf_full),
    .out_valid(rd_valid),
    .out_data(rd_data),
    .out_ready(rd_ready)
  );

  // ==========================================================
  // Outputs
  assign wr_ready = wr_ready_q;
  assign link_ready = run_q;
  assign master_clear_n = clear_n_q;
  assign load_strobe = load_stb_q;
  assign write_word = word_q;
  assign unload_strobe_n = unload_n_q;
  assign output_enable_n = oe_n_q;

  // ==========================================================
  // Checks
  logic clear_done_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      clear_done_q <= 1'b0;
    end
    else if ($rose(clear_n_q))
    begin
      clear_done_q <= 1'b1;
    end
  end

  a_load_after_clear: assert property (@(posedge sys_clk) disable iff (reset) load_stb_q |-> clear_done_q)
    else $error("load strobe before master clear pulse");

  a_clear_pulse_width: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(clear_n_q) |-> $past(!clear_n_q, 1) && $past(!clear_n_q, 2))
    else $error("master clear pulse too short");

  a_no_strobe_clear: assert property (@(posedge sys_clk) disable iff (reset)
    !clear_n_q |-> !load_stb_q && !unload_n_q)
    else $error("strobe active during master clear");

  a_load_when_ready: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(load_stb_q) |-> $past(in_rdy_q, 2))
    else $error("load without input ready");

  a_load_pulse_shape: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(load_stb_q) |-> load_stb_q[*4] ##1 (!load_stb_q)[*3])
    else $error("load strobe width wrong");

  a_word_held_load: assert property (@(posedge sys_clk) disable iff (reset)
    $past(load_stb_q) |-> $stable(word_q))
    else $error("write word changed during load");

  a_unload_pulse_shape: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(unload_n_q) |-> unload_n_q[*3] ##1 (!unload_n_q)[*5])
    else $error("unload strobe width or spacing wrong");

  a_unload_needs_flag: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(unload_n_q) |-> $past(out_rdy_q, 2) && $past(push))
    else $error("unload without output ready");

endmodule // fifo_host
`default_nettype wire

/* File: verification/fifo_store_model.sv */
// Behavioural model of the 64x9 ripple-through store
`timescale 1ns/1ps
`default_nettype none
module fifo_store_model #(
  parameter int RIPPLE_NS = 300,
  parameter int RELEASE_NS = 60
) (
  input wire logic master_clear_n,
  input wire logic load_strobe,
  input wire logic [fifo_host_pkg::WORD_W-1:0] write_word,
  output logic input_ready,
  input wire logic unload_strobe_n,
  input wire logic output_enable_n,
  output logic output_ready_flag,
  output logic [fifo_host_pkg::WORD_W-1:0] read_word,
  output int misuse_count
);
  // ==========================================================
  // Store state
  logic [fifo_host_pkg::WORD_W-1:0] store_q[$];
  logic [fifo_host_pkg::WORD_W-1:0] hold_word;
  logic [fifo_host_pkg::WORD_W-1:0] next_word;
  logic [fifo_host_pkg::WORD_W-1:0] out_word = 9'h1a5;
  int cnt = 0;
  logic in_busy = 1'b0;
  logic out_full = 1'b0;
  logic unload_high = 1'b0;

  // ==========================================================
  // Clear empties locations and output stage, output word kept
  always @(negedge master_clear_n)
  begin
    store_q.delete();
    cnt = 0;
    in_busy = 1'b0;
    out_full = 1'b0;
  end
  always @(posedge master_clear_n)
  begin
    if (load_strobe)
    begin
      hold_word = write_word;
      in_busy = 1'b1;
    end
  end

  // ==========================================================
  // Input stage
  initial misuse_count = 0;
  always @(posedge load_strobe)
  begin
    if (!master_clear_n || !input_ready)
      misuse_count = misuse_count + 1;
    else
    begin
      hold_word = write_word;
      in_busy = 1'b1;
    end
  end
  always @(negedge load_strobe)
  begin
    if (in_busy)
    begin
      #RELEASE_NS;
      if (in_busy)
      begin
        store_q.push_back(hold_word);
        cnt = cnt + 1;
        in_busy = 1'b0;
      end
    end
  end

  // ==========================================================
  // Ripple to output stage, flag before word
  always
  begin
    wait (master_clear_n && !out_full && !unload_high && cnt > 0);
    #RIPPLE_NS;
    if (master_clear_n && !out_full && !unload_high && cnt > 0)
    begin
      next_word = store_q.pop_front();
      cnt = cnt - 1;
      out_full = 1'b1;
      #30;
      out_word = next_word;
    end
  end

  // ==========================================================
  // Output stage
  always @(posedge unload_strobe_n)
  begin
    if (!output_ready_flag)
      misuse_count = misuse_count + 1;
    unload_high = 1'b1;
    out_full = 1'b0;
  end
  always @(negedge unload_strobe_n)
    unload_high = 1'b0;

  assign input_ready = !master_clear_n || (!in_busy && (cnt + out_full) < fifo_host_pkg::STORE_DEPTH);
  assign output_ready_flag = master_clear_n && out_full && !unload_high;
  assign read_word = output_enable_n ? ~out_word : out_word;
endmodule  // fifo_store_model
`default_nettype wire

/* File: verification/tb_fifo_host.sv */
// Self-checking bench for the store controller against a behavioural store
`timescale 1ns/1ps
`default_nettype none
module tb_fifo_host;
  // ==========================================================
  // Signals
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic wr_valid = 1'b0;
  logic rd_ready = 1'b0;
  logic [fifo_host_pkg::WORD_W-1:0] wr_data = 9'h000;
  logic wr_ready, rd_valid, link_ready, master_clear_n, load_strobe;
  logic input_ready, unload_strobe_n, output_enable_n, output_ready_flag;
  logic [fifo_host_pkg::WORD_W-1:0] rd_data, write_word, read_word;
  logic [fifo_host_pkg::WORD_W-1:0] exp_q[$];
  int seed = 90505;
  int err_count = 0;
  int cmp_count = 0;
  int acc_count = 0;
  int last_acc = 0;
  int base;
  int misuse_count;
  int i;

  initial forever #20 sys_clk = ~sys_clk;

  fifo_host DUT (.sys_clk(sys_clk), .reset(reset), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .link_ready(link_ready),
    .master_clear_n(master_clear_n), .load_strobe(load_strobe), .write_word(write_word),
    .input_ready(input_ready), .unload_strobe_n(unload_strobe_n), .output_enable_n(output_enable_n),
    .output_ready_flag(output_ready_flag), .read_word(read_word));
  fifo_store_model store (.master_clear_n(master_clear_n), .load_strobe(load_strobe), .write_word(write_word),
    .input_ready(input_ready), .unload_strobe_n(unload_strobe_n), .output_enable_n(output_enable_n),
    .output_ready_flag(output_ready_flag), .read_word(read_word), .misuse_count(misuse_count));

  // ==========================================================
  // Helpers
  function automatic int fill_expected();
    return fifo_host_pkg::STORE_DEPTH + 2;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic bound(input logic ok);
    check(ok, 1'b1);
    if (ok !== 1'b1)
      stop_test();
  endtask

  // New word only once the last one was taken
  task automatic step(input int pct);
    @(negedge sys_clk);
    if (!wr_valid || acc_count != last_acc)
    begin
      last_acc = acc_count;
      wr_valid = ($random(seed) & 32'h7f) < pct;
      wr_data = 9'($random(seed));
    end
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 6000 && (exp_q.size() > 0 || wr_valid); k++)
    begin
      step(0);
      rd_ready = 1'($random(seed));
    end
    bound(exp_q.size() == 0 && !wr_valid);
  endtask

  // ==========================================================
  // Scoreboard
  always @(posedge sys_clk)
  begin
    if (!reset && wr_valid && wr_ready)
    begin
      exp_q.push_back(wr_data);
      acc_count++;
    end
    if (!reset && rd_valid && rd_ready)
    begin
      check(exp_q.size() > 0, 1'b1);
      if (exp_q.size() > 0)
        check(rd_data, exp_q.pop_front());
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(negedge sys_clk);
    check(master_clear_n, 1'b0);
    check(output_enable_n, 1'b1);
    check(load_strobe, 1'b0);
    check(wr_ready, 1'b0);
    check(rd_valid, 1'b0);
    reset = 1'b0;
    @(negedge sys_clk);
    check(master_clear_n, 1'b0);
    for (i = 0; i < 50 && link_ready !== 1'b1; i++)
      @(negedge sys_clk);
    bound(link_ready === 1'b1);
    check(master_clear_n, 1'b1);
    check(output_enable_n, 1'b0);
    // Random traffic, consumer stalls often
    for (i = 0; i < 1500; i++)
    begin
      step(100);
      rd_ready = 1'($random(seed));
    end
    drain();
    // Fill until refused, consumer stalled
    rd_ready = 1'b0;
    base = acc_count;
    for (i = 0; i < 1500; i++)
      step(128);
    check(acc_count - base, fill_expected());
    check(load_strobe, 1'b0);
    check(rd_valid, 1'b1);
    drain();
    rd_ready = 1'b0;
    repeat (40) step(0);
    check(rd_valid, 1'b0);
    check(misuse_count, 0);
    check(unload_strobe_n, 1'b0);
    stop_test();
  end
endmodule  // tb_fifo_host
`default_nettype wire
